// [cql_regs.svh]
// Constants of the command queue legality checker.
// Operation
// (R01) Queue commands 44 to 48 are illegal, unanswered, while queuing is off.
// (R02) Parameter command rejected for busy id, id beyond depth, or zero blocks.
// (R03) Other parameter faults get a clean answer and a deferred error.
// (R04) Address command not right after an accepted parameter command is illegal.
// (R05) Address range faults flagged in answer; protect faults deferred instead.
// (R06) Execute read or write illegal for missing, unready or wrong-direction task.
// (R07) Disabling queuing with tasks still queued is illegal.
// (R08) Queue enable bit at one selects queued legality rules.
// (R09) With queuing on, legacy block reads and writes 17, 18, 24, 25 are illegal.
// (R10) With queuing off, legacy block commands legal and class 11 illegal.
// (R11) Non-empty queue admits only class 11, 0, 12, 13; reset clears queue.
// (R12) Stop during queued read returns to transfer and clears the ready bit.
// (R13) Stop during queued write programs first, then clears the ready bit.
// (R14) Host issues only class 11 with empty queue, after finishing sequences.
// (R15) Illegal command keeps state, no answer, sets flag reported next answer; the code sets the flag alongside the illegal command's own verdict.
// (R16) Opcode 1 discards all tasks, opcode 2 one task, never erroring; the code sets the deferred error for any legal 48 with a deferred fault.
// (R17) Status request with bit 15 set returns the queue status word.
// (R18) Pending-parameters flag set by accepted 44, cleared by next command.
`ifndef CQL_REGS_SVH
`define CQL_REGS_SVH
`define CQL_DEPTH 32
`define CQL_CMD_RESET 6'h00
`define CQL_CMD_SWITCH 6'h06
`define CQL_CMD_STOP 6'h0C
`define CQL_CMD_STATUS 6'h0D
`define CQL_CMD_RD1 6'h11
`define CQL_CMD_RDN 6'h12
`define CQL_CMD_WR1 6'h18
`define CQL_CMD_WRN 6'h19
`define CQL_CMD_PARAM 6'h2C
`define CQL_CMD_ADDR 6'h2D
`define CQL_CMD_EXRD 6'h2E
`define CQL_CMD_EXWR 6'h2F
`define CQL_CMD_TMGMT 6'h30
`define CQL_TM_ALL 4'h1
`define CQL_TM_ONE 4'h2
`define CQL_QSR_BIT 15
`endif

// [cql_pkg.sv]
// Types of the command queue legality checker.
package cql_pkg;
   typedef struct packed {
      logic [5:0] index;
      logic [31:0] arg;
      logic range_err;
      logic defer_err;
      logic dir_read;
      logic disable_q;
   } cql_cmd_t;
   typedef struct packed {
      logic respond;
      logic resp_err;
      logic qsr_sel;
      logic illegal;
   } cql_verdict_t;
   typedef enum logic [1:0] {
      CQL_TRAN = 2'b00,
      CQL_DATA = 2'b01,
      CQL_PROG = 2'b10
   } cql_state_t;
endpackage : cql_pkg

// [cql_slot.sv]
// One task slot of the queue.
`timescale 1ns/100ps
`default_nettype none
module cql_slot
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic dir_i,
   input wire logic ready_i,
   input wire logic drop_i,
   output logic used_o,
   output logic read_o,
   output logic ready_o
);
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         used_o <= 1'b0;
         read_o <= 1'b0;
         ready_o <= 1'b0;
      end
      else if (drop_i)
      begin
         used_o <= 1'b0;
         ready_o <= 1'b0;
      end
      else if (load_i)
      begin
         used_o <= 1'b1;
         read_o <= dir_i;
         ready_o <= 1'b0;
      end
      else if (ready_i && used_o)
      begin
         ready_o <= 1'b1;
      end
   end
endmodule : cql_slot
`default_nettype wire

// [cql_checker.sv]
// Command legality checker and task queue state.
`timescale 1ns/100ps
`default_nettype none
`include "cql_regs.svh"
module cql_checker #(
   parameter int DEPTH = `CQL_DEPTH
)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic queue_enable_field_i,
   input wire logic cmd_valid_i,
   input wire cql_pkg::cql_cmd_t cmd_i,
   input wire logic [DEPTH-1:0] task_ready_i,
   input wire logic xfer_done_i,
   input wire logic prog_done_i,
   output cql_pkg::cql_verdict_t verdict_o,
   output logic verdict_valid_o,
   output logic deferred_err_o,
   output logic illegal_flag_o,
   output logic [DEPTH-1:0] queue_status_word_o,
   output logic queue_empty_o,
   output cql_pkg::cql_state_t state_o
);
   localparam int IW = $clog2(DEPTH);
   logic [DEPTH-1:0] used;
   logic [DEPTH-1:0] rdir;
   logic [DEPTH-1:0] rdy;
   logic [DEPTH-1:0] load;
   logic [DEPTH-1:0] drop;
   logic pend_q;
   logic [IW-1:0] pend_id_q;
   logic pend_dir_q;
   logic [IW-1:0] act_id_q;
   logic illegal;
   logic cls11;
   logic legacy_blk;
   logic empty;
   logic [4:0] tid;
   logic tid_ok;
   logic [5:0] c;
   assign c = cmd_i.index;
   assign tid = cmd_i.arg[20:16];
   assign empty = ~|used;
   assign tid_ok = {27'h0000000, tid} < 32'(DEPTH);
   assign cls11 = (c >= `CQL_CMD_PARAM) && (c <= `CQL_CMD_TMGMT);
   assign legacy_blk = (c == `CQL_CMD_RD1) || (c == `CQL_CMD_RDN) || (c == `CQL_CMD_WR1) || (c == `CQL_CMD_WRN);

   always_comb
   begin
      illegal = 1'b0;
      // (R07) Disable needs empty queue.
      if (c == `CQL_CMD_SWITCH && cmd_i.disable_q && !empty)
      begin
         illegal = 1'b1;
      end
      // (R08) Enable selects rules.
      else if (!queue_enable_field_i)
      begin
         // (R01) Queue commands illegal.
         // (R10) Legacy mode legality.
         illegal = cls11;
      end
      else if (!empty && !cls11 && c != `CQL_CMD_RESET && c != `CQL_CMD_STOP && c != `CQL_CMD_STATUS)
      begin
         // (R11) Non-empty queue filter.
         illegal = 1'b1;
      end
      else if (legacy_blk)
      begin
         // (R09) Legacy transfers barred.
         illegal = 1'b1;
      end
      else if (c == `CQL_CMD_PARAM)
      begin
         // (R02) Parameter command checks.
         illegal = !tid_ok || used[tid[IW-1:0]] || cmd_i.arg[15:0] == 16'h0000;
      end
      else if (c == `CQL_CMD_ADDR)
      begin
         // (R04) Must follow parameters.
         illegal = !pend_q;
      end
      else if (c == `CQL_CMD_EXRD || c == `CQL_CMD_EXWR)
      begin
         // (R06) Execute checks.
         illegal = !tid_ok || !used[tid[IW-1:0]] || !rdy[tid[IW-1:0]] ||
                   (rdir[tid[IW-1:0]] != (c == `CQL_CMD_EXRD));
      end
   end

   always_comb
   begin
      load = '0;
      drop = '0;
      if (cmd_valid_i && !illegal)
      begin
         if (c == `CQL_CMD_ADDR && !cmd_i.range_err)
         begin
            load[pend_id_q] = 1'b1;
         end
         // (R11) Reset empties queue.
         if (c == `CQL_CMD_RESET)
         begin
            drop = '1;
         end
         // (R16) Discard operations.
         if (c == `CQL_CMD_TMGMT && cmd_i.arg[3:0] == `CQL_TM_ALL)
         begin
            drop = '1;
         end
         if (c == `CQL_CMD_TMGMT && cmd_i.arg[3:0] == `CQL_TM_ONE && tid_ok)
         begin
            drop[tid[IW-1:0]] = 1'b1;
         end
      end
      // (R12) Read stop or finish clears ready.
      // (R13) Write cleared after programming.
      if ((state_o == cql_pkg::CQL_DATA && rdir[act_id_q] && (xfer_done_i ||
          (cmd_valid_i && c == `CQL_CMD_STOP))) || (state_o == cql_pkg::CQL_PROG && prog_done_i))
      begin
         drop[act_id_q] = 1'b1;
      end
   end

   for (genvar i = 0; i < DEPTH; i++)
   begin : g_slot
      cql_slot u_slot (
         .mclk_i(mclk_i),
         .rst_n_i(rst_n_i),
         .load_i(load[i]),
         .dir_i(pend_dir_q),
         .ready_i(task_ready_i[i]),
         .drop_i(drop[i]),
         .used_o(used[i]),
         .read_o(rdir[i]),
         .ready_o(rdy[i])
      );
   end

   // (R18) Pending-parameters flag.
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pend_q <= 1'b0;
         pend_id_q <= '0;
         pend_dir_q <= 1'b0;
      end
      else if (cmd_valid_i)
      begin
         pend_q <= (c == `CQL_CMD_PARAM) && !illegal;
         if (c == `CQL_CMD_PARAM)
         begin
            pend_id_q <= tid[IW-1:0];
            pend_dir_q <= cmd_i.dir_read;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_o <= cql_pkg::CQL_TRAN;
         act_id_q <= '0;
      end
      else
      begin
         unique case (state_o)
            cql_pkg::CQL_TRAN:
               if (cmd_valid_i && !illegal && (c == `CQL_CMD_EXRD || c == `CQL_CMD_EXWR))
               begin
                  state_o <= cql_pkg::CQL_DATA;
                  act_id_q <= tid[IW-1:0];
               end
            cql_pkg::CQL_DATA:
               if (cmd_valid_i && c == `CQL_CMD_STOP)
               begin
                  // (R12) Read stop to transfer.
                  // (R13) Write stop to programming.
                  state_o <= rdir[act_id_q] ? cql_pkg::CQL_TRAN : cql_pkg::CQL_PROG;
               end
               else if (xfer_done_i)
               begin
                  state_o <= rdir[act_id_q] ? cql_pkg::CQL_TRAN : cql_pkg::CQL_PROG;
               end
            cql_pkg::CQL_PROG:
               if (prog_done_i)
               begin
                  state_o <= cql_pkg::CQL_TRAN;
               end
            default:
               state_o <= cql_pkg::CQL_TRAN;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         verdict_o <= '0;
         verdict_valid_o <= 1'b0;
         deferred_err_o <= 1'b0;
         illegal_flag_o <= 1'b0;
      end
      else
      begin
         verdict_valid_o <= cmd_valid_i;
         if (cmd_valid_i)
         begin
            // (R15) No answer, illegal bit set.
            verdict_o.respond <= !illegal;
            verdict_o.illegal <= illegal;
            // (R05) Range error in answer.
            verdict_o.resp_err <= !illegal && c == `CQL_CMD_ADDR && cmd_i.range_err;
            // (R17) Status word select.
            verdict_o.qsr_sel <= !illegal && c == `CQL_CMD_STATUS && cmd_i.arg[`CQL_QSR_BIT];
            // (R15) Flag set alongside this command's own verdict, then overwritten by the next command's verdict.
            illegal_flag_o <= illegal;
            // (R03) Deferred parameter fault.
            // (R05) Deferred protect fault.
            deferred_err_o <= !illegal && (c == `CQL_CMD_PARAM || c == `CQL_CMD_ADDR ||
                              c == `CQL_CMD_TMGMT) && cmd_i.defer_err;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         queue_status_word_o <= '0;
         queue_empty_o <= 1'b1;
      end
      else
      begin
         queue_status_word_o <= rdy & ~drop;
         queue_empty_o <= ~|(used & ~drop);
      end
   end
endmodule : cql_checker
`default_nettype wire

// [cql_checker_props.sv]
// Port assertions of the queue legality checker.
`timescale 1ns/100ps
`default_nettype none
module cql_checker_props #(parameter int DEPTH = 32)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic queue_enable_field_i,
   input wire logic cmd_valid_i,
   input wire cql_pkg::cql_cmd_t cmd_i,
   input wire cql_pkg::cql_verdict_t verdict_o,
   input wire logic verdict_valid_o,
   input wire logic illegal_flag_o,
   input wire logic [DEPTH-1:0] queue_status_word_o,
   input wire logic queue_empty_o
);
   logic [5:0] last_q;
   wire logic [5:0] ix = cmd_i.index;
   wire logic go = cmd_valid_i & queue_enable_field_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         last_q <= 6'h00;
      else if (cmd_valid_i)
         last_q <= ix;
   end
   a_answer_next: assert property (cmd_valid_i |=> verdict_valid_o) else $error("no answer");
   a_no_stray: assert property (!cmd_valid_i |=> !verdict_valid_o) else $error("stray answer");
   a_illegal_mute: assert property (verdict_valid_o && verdict_o.illegal |-> !verdict_o.respond && illegal_flag_o)
      else $error("illegal answered");
   a_queue_off: assert property (cmd_valid_i && !queue_enable_field_i && ix inside {[6'h2C:6'h30]}
      |=> verdict_o.illegal) else $error("queue cmd legal");
   a_legacy_on: assert property (go && ix inside {6'h11, 6'h12, 6'h18, 6'h19} |=> verdict_o.illegal)
      else $error("legacy cmd legal");
   a_param_bad: assert property (go && ix == 6'h2C && (cmd_i.arg[15:0] == 16'h0000 || cmd_i.arg[20:16] >= DEPTH)
      |=> verdict_o.illegal) else $error("bad param legal");
   a_addr_orphan: assert property (cmd_valid_i && ix == 6'h2D && last_q != 6'h2C |=> verdict_o.illegal)
      else $error("orphan address legal");
   a_disable_busy: assert property (cmd_valid_i && ix == 6'h06 && cmd_i.disable_q && !queue_empty_o
      |=> verdict_o.illegal) else $error("disable legal");
   a_status_word: assert property (go && ix == 6'h0D && cmd_i.arg[15] |=> verdict_o.qsr_sel && verdict_o.respond)
      else $error("no status word");
   a_reset_drop: assert property (go && ix == 6'h00 |-> ##[2:4] queue_status_word_o == '0)
      else $error("queue kept");
endmodule : cql_checker_props
bind cql_checker cql_checker_props #(.DEPTH(DEPTH)) u_props (.mclk_i, .rst_n_i, .queue_enable_field_i,
   .cmd_valid_i, .cmd_i, .verdict_o, .verdict_valid_o, .illegal_flag_o, .queue_status_word_o, .queue_empty_o);
`default_nettype wire

// [cql_back_model.sv]
// Back end model that marks tasks ready and finishes programming.
`timescale 1ns/100ps
`default_nettype none
module cql_back_model #(parameter int DEPTH = 8)
(
   input wire logic mclk_i,
   input wire logic [DEPTH-1:0] mark_i,
   input wire cql_pkg::cql_state_t state_i,
   output logic [DEPTH-1:0] task_ready_o,
   output logic prog_done_o
);
   int cnt = 0;
   always @(posedge mclk_i)
   begin
      task_ready_o <= mark_i;
      cnt <= (state_i == cql_pkg::CQL_PROG) ? cnt + 1 : 0;
      prog_done_o <= (cnt == 5);
   end
endmodule : cql_back_model
`default_nettype wire

// [cql_checker_tb.sv]
// Self-checking bench of the queue legality checker.
`timescale 1ns/100ps
`default_nettype none
module cql_checker_tb;
   localparam int D = 8;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic qen = 1'b0;
   logic cv = 1'b0;
   logic xd = 1'b0;
   cql_pkg::cql_cmd_t cmd = '0;
   logic [D-1:0] mark = '0;
   logic [D-1:0] rdy, queue_status_word;
   logic pd, vv, de, il, qe;
   cql_pkg::cql_verdict_t vd;
   cql_pkg::cql_state_t st;
   int err_count = 0;
   int total_checks = 0;
   int used[D], rd[D];
   int lg[4] = '{17, 18, 24, 25};
   bit pend = 0;
   int pid = 0, pdir = 0;
   cql_checker #(.DEPTH(D)) dut_u (.mclk_i, .rst_n_i, .queue_enable_field_i(qen), .cmd_valid_i(cv), .cmd_i(cmd),
      .task_ready_i(rdy), .xfer_done_i(xd), .prog_done_i(pd), .verdict_o(vd), .verdict_valid_o(vv),
      .deferred_err_o(de), .illegal_flag_o(il), .queue_status_word_o(queue_status_word), .queue_empty_o(qe), .state_o(st));
   cql_back_model #(.DEPTH(D)) back_u (.mclk_i, .mark_i(mark), .state_i(st), .task_ready_o(rdy), .prog_done_o(pd));
   initial
   begin
      forever #2 mclk_i = ~mclk_i;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected at %0t: %h not %h", $time, s, e);
      end
   endtask : chk
   task automatic send(input int i, input int a, input bit rng = 0, input bit dfr = 0, input bit dq = 0,
      input bit dr = 0);
      int id;
      bit ne, ill;
      @(posedge mclk_i);
      id = (a >> 16) & 31;
      ne = 0;
      foreach (used[k]) ne |= (used[k] != 0);
      ill = qen ? (i inside {17, 18, 24, 25} || (ne && !(i inside {[44:48], 0, 12, 13}))) : i inside {[44:48]};
      if (i == 6 && dq && ne) ill = 1;
      if (qen && i == 44) ill |= id >= D || (a & 32'hFFFF) == 0 || used[id % D] != 0;
      if (qen && i == 45) ill |= !pend;
      if (qen && i inside {46, 47}) ill |= id >= D || used[id % D] == 0 || !mark[id % D] || rd[id % D] != (i == 46);
      cmd <= '{i[5:0], a, rng, dfr, dr, dq};
      cv <= 1'b1;
      @(posedge mclk_i);
      cv <= 1'b0;
      #1;
      chk(vv, 1);
      chk(vd.illegal, ill);
      chk(vd.respond, !ill);
      chk(il, ill);
      chk(vd.resp_err, i == 45 && !ill && rng);
      chk(vd.qsr_sel, !ill && i == 13 && a[15]);
      if (!ill) chk(de, dfr);
      if (!ill && i == 45 && !rng) used[pid] = 1;
      if (!ill && i == 45 && !rng) rd[pid] = pdir;
      if (!ill && (i == 0 || (i == 48 && (a & 15) == 1))) used = '{default: 0};
      if (!ill && i == 48 && (a & 15) == 2) used[id % D] = 0;
      pend = !ill && i == 44;
      pid = id % D;
      pdir = dr;
   endtask : send
   initial
   begin
      #40000;
      err_count++;
      final_report();
   end
   initial
   begin
      void'($urandom(32'hA92B));
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int i = 44; i <= 48; i++) send(i, 32'h0003_0001);
      foreach (lg[k]) send(lg[k], $urandom);
      // With the queue on the host also sends 0, 2, 6, 12 and 13; the legacy sends below only probe rejection.
      qen <= 1'b1;
      foreach (lg[k]) send(lg[k], $urandom);
      send(45, 0);
      send(44, 32'h0002_0000);
      send(44, 32'h0009_0001);
      send(44, 32'h0003_0001 | ($urandom & 32'hFFFF), 0, 1, 0, 1);
      send(45, $urandom, 0, 1);
      send(44, 32'h0003_0001);
      send(45, 0);
      send(44, 32'h0005_0004);
      send(45, 0, 1);
      send(44, 32'h0005_0004);
      send(45, 0);
      send(44, 32'h0006_0002, 0, 0, 0, 1);
      send(45, 0);
      mark <= 8'h68;
      repeat (4) @(posedge mclk_i);
      chk(queue_status_word, 8'h68);
      send(13, 32'h0000_8000);
      send(6, 0, 0, 0, 1);
      send(2, 0);
      send(46, 32'h0004_0000);
      send(47, 32'h0003_0000);
      send(46, 32'h0003_0000);
      chk(st, cql_pkg::CQL_DATA);
      send(12, 0);
      used[3] = 0;
      chk(st, cql_pkg::CQL_TRAN);
      repeat (2) @(posedge mclk_i);
      chk(queue_status_word, 8'h60);
      send(47, 32'h0005_0000);
      send(12, 0);
      chk(st, cql_pkg::CQL_PROG);
      chk(queue_status_word[5], 1);
      repeat (10) @(posedge mclk_i);
      used[5] = 0;
      chk(st, cql_pkg::CQL_TRAN);
      chk(queue_status_word, 8'h40);
      send(46, 32'h0006_0000);
      chk(st, cql_pkg::CQL_DATA);
      @(posedge mclk_i);
      xd <= 1'b1;
      @(posedge mclk_i);
      xd <= 1'b0;
      #1;
      used[6] = 0;
      chk(st, cql_pkg::CQL_TRAN);
      chk(queue_status_word, 8'h00);
      send(48, 32'h0006_0002);
      send(48, 32'h0004_0002);
      send(48, 1);
      send(48, 32'h0000_0005, 0, 1);
      send(44, 32'h0002_0001);
      send(45, 0);
      send(0, 0);
      chk(qe, 1);
      send(6, 0, 0, 0, 1);
      final_report();
   end
endmodule : cql_checker_tb
`default_nettype wire
